/* core/fmac_pkg.sv */
package fmac_pkg;

    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_EN     = 8'h06;
    localparam logic [7:0] OP_WRITE_DIS    = 8'h04;
    localparam logic [7:0] OP_VOL_SR_WE    = 8'h50;
    localparam logic [7:0] OP_WRITE_SR1    = 8'h01;
    localparam logic [7:0] OP_WRITE_SR2    = 8'h31;
    localparam logic [7:0] OP_READ_SR1     = 8'h05;
    localparam logic [7:0] OP_READ_SR2     = 8'h35;
    localparam logic [7:0] OP_RESET_EN     = 8'h66;
    localparam logic [7:0] OP_RESET        = 8'h99;
    localparam logic [7:0] OP_ENTER_4B     = 8'hb7;
    localparam logic [7:0] OP_EXIT_4B      = 8'he9;
    localparam logic [7:0] OP_READ_EXT     = 8'hc8;
    localparam logic [7:0] OP_WRITE_EXT    = 8'hc5;
    localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
    localparam logic [7:0] OP_ENTER_4WIRE  = 8'h38;
    localparam logic [7:0] OP_EXIT_4WIRE   = 8'hff;

    // ------------------------------------------------------------
    // Mode byte values
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_CONT_ENTER = 8'ha5;
    localparam logic [7:0] MODE_CONT_EXIT  = 8'h00;

    // ------------------------------------------------------------
    // Field positions, masks and reset values
    // ------------------------------------------------------------
    localparam int unsigned   SR1_BUSY_BIT    = 0;
    localparam int unsigned   SR1_WEL_BIT     = 1;
    localparam int unsigned   SR2_QE_BIT      = 1;
    localparam logic [7:0]    SR1_WR_MASK     = 8'hfc;
    localparam logic [7:0]    SR2_WR_MASK     = 8'h02;
    localparam logic [7:0]    SR_RESET        = 8'h00;
    localparam logic [7:0]    EXT_ADDR_RESET  = 8'h00;
    localparam logic [31:0]   ADDR_RESET      = 32'h0000_0000;
    localparam logic [3:0]    ALL_ONES_NIB    = 4'hf;
    localparam logic [3:0]    OE_SINGLE       = 4'h2;
    localparam logic [3:0]    OE_QUAD         = 4'hf;

    // ------------------------------------------------------------
    // Phase lengths in link clocks
    // ------------------------------------------------------------
    localparam logic [3:0] LEN_BYTE_SINGLE = 4'h8;
    localparam logic [3:0] LEN_BYTE_QUAD   = 4'h2;
    localparam logic [3:0] LEN_ADDR_3B     = 4'h6;
    localparam logic [3:0] LEN_ADDR_4B     = 4'h8;
    localparam logic [3:0] LEN_MODE        = 4'h2;
    localparam logic [3:0] LEN_DUMMY       = 4'h4;
    localparam logic [3:0] LEN_ONES_3B     = 4'h8;
    localparam logic [3:0] LEN_ONES_4B     = 4'ha;

    // ------------------------------------------------------------
    // Link phase states
    // ------------------------------------------------------------
    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_CMD    = 8'h02,
        ST_ADDR   = 8'h04,
        ST_MODE   = 8'h08,
        ST_DUMMY  = 8'h10,
        ST_DIN    = 8'h20,
        ST_DOUT   = 8'h40,
        ST_IGNORE = 8'h80
    } fmac_phase_t;

    // Published device state, carried from link to core domain
    typedef struct packed {
        logic        four_byte_mode;
        logic        cont_read_active;
        logic        four_wire_command_mode;
        logic        quad_enable_bit;
        logic        volatile_sr1_active;
        logic [7:0]  status1;
        logic [7:0]  status2;
        logic [7:0]  ext_addr;
        logic [31:0] read_addr;
        logic        read_seq;
        logic        sreset_seq;
    } fmac_state_t;

endpackage

/* core/fmac_top.sv */
`timescale 1ns/1ns
`default_nettype none

module fmac_top
(
    // Core side
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    // Link pins
    input  wire logic                 link_sclk,
    input  wire logic                 link_cs_n,
    input  wire logic [3:0]           link_io_in,
    output logic      [3:0]           link_io_out,
    output logic      [3:0]           link_io_oe,
    // Device state seen by the core
    output fmac_pkg::fmac_state_t     dev_state,
    output logic                      read_start,
    output logic                      soft_reset_done
);
    import fmac_pkg::*;

    // ------------------------------------------------------------
    // Link domain: frame state
    // ------------------------------------------------------------
    // Frame logic clears on chip select high; the link clock may stop
    // between frames, so nothing here waits for an edge after a frame.
    logic        frame_rst;
    fmac_phase_t state_r;
    fmac_phase_t state_nxt;
    fmac_phase_t eff_state;
    logic [3:0]  cnt_r;
    logic [7:0]  sh_r;
    logic [7:0]  sh_nxt;
    logic [7:0]  cmd_r;
    logic [31:0] addr_r;
    logic [31:0] addr_nxt;
    logic [7:0]  rd_val_r;
    logic [3:0]  ones_cnt_r;
    logic        ones_run_r;
    logic        cont_frame_r;
    logic        cont_frame;
    logic        wide;
    logic [3:0]  phase_len;
    logic        last;
    logic        cmd_done;
    logic        mode_done;
    logic        din_done;
    logic        ones_exit;

    // Persistent link state
    logic        four_byte_r;
    logic        cont_read_r;
    logic        four_wire_r;
    logic        wel_r;
    logic        vol_we_r;
    logic        vol_act_r;
    logic        rst_en_r;
    logic [7:0]  sr1_nv_r;
    logic [7:0]  sr1_vol_r;
    logic [7:0]  sr2_r;
    logic [7:0]  ext_addr_r;
    logic [31:0] rd_addr_r;
    logic        rd_seq_r;
    logic        sreset_seq_r;
    logic [7:0]  sr1_view;
    logic        qe;

    // Output shifter (falling edge)
    logic [7:0]  osh_r;
    logic [2:0]  ocnt_r;
    logic [7:0]  obyte;

    // Crossing
    fmac_state_t pub_r;
    fmac_state_t pub_nxt;
    logic        pub_tog_r;
    logic [2:0]  tog_sync_r;
    fmac_state_t core_state_r;
    logic        read_start_r;
    logic        soft_reset_r;

    // Picks the phase that follows a completed instruction byte
    function automatic fmac_phase_t phase_after_cmd(input logic [7:0] op,
                                                    input logic       quad_ok);
        fmac_phase_t p;
        p = ST_IGNORE;
        case (op)
            OP_QUAD_IO_READ: p = quad_ok ? ST_ADDR : ST_IGNORE;
            OP_WRITE_SR1:    p = ST_DIN;
            OP_WRITE_SR2:    p = ST_DIN;
            OP_WRITE_EXT:    p = ST_DIN;
            OP_READ_SR1:     p = ST_DOUT;
            OP_READ_SR2:     p = ST_DOUT;
            OP_READ_EXT:     p = ST_DOUT;
            default:         p = ST_IGNORE;
        endcase
        return p;
    endfunction

    // Async clear by chip select; chip select is glitch-free from the host
    assign frame_rst = reset | link_cs_n;
    assign qe        = sr2_r[SR2_QE_BIT];
    assign sr1_view  = {vol_act_r ? sr1_vol_r[7:2] : sr1_nv_r[7:2], wel_r, 1'b0};

    // ------------------------------------------------------------
    // Link domain: phase decode
    // ------------------------------------------------------------
    always_comb
    begin
        // A frame in continuous-read mode starts straight at the address
        eff_state  = (state_r == ST_IDLE) ? (cont_read_r ? ST_ADDR : ST_CMD) : state_r;
        cont_frame = (state_r == ST_IDLE) ? cont_read_r : cont_frame_r;
        wide       = 1'b0;
        phase_len  = LEN_BYTE_SINGLE;
        case (eff_state)
            ST_CMD:
            begin
                wide      = four_wire_r;
                phase_len = four_wire_r ? LEN_BYTE_QUAD : LEN_BYTE_SINGLE;
            end
            ST_ADDR:
            begin
                wide      = 1'b1;
                phase_len = four_byte_r ? LEN_ADDR_4B : LEN_ADDR_3B;
            end
            ST_MODE:
            begin
                wide      = 1'b1;
                phase_len = LEN_MODE;
            end
            ST_DUMMY:
            begin
                wide      = 1'b1;
                phase_len = LEN_DUMMY;
            end
            ST_DIN:
            begin
                wide      = four_wire_r;
                phase_len = four_wire_r ? LEN_BYTE_QUAD : LEN_BYTE_SINGLE;
            end
            default:
            begin
                wide      = 1'b0;
                phase_len = LEN_BYTE_SINGLE;
            end
        endcase
        last      = (cnt_r == phase_len - 4'h1);
        sh_nxt    = wide ? {sh_r[3:0], link_io_in} : {sh_r[6:0], link_io_in[0]};
        addr_nxt  = {addr_r[27:0], link_io_in};
        cmd_done  = (eff_state == ST_CMD) && last;
        mode_done = (eff_state == ST_MODE) && last;
        din_done  = (eff_state == ST_DIN) && last;
        // All-ones run counted from the first clock of a continuous frame
        ones_exit = cont_frame && ones_run_r && (link_io_in == ALL_ONES_NIB) &&
                    (ones_cnt_r == ((four_byte_r ? LEN_ONES_4B : LEN_ONES_3B) - 4'h1));
        state_nxt = eff_state;
        if (ones_exit)
            state_nxt = ST_IGNORE;
        else if (last)
        begin
            case (eff_state)
                ST_CMD:   state_nxt = phase_after_cmd(sh_nxt, qe);
                ST_ADDR:  state_nxt = ST_MODE;
                ST_MODE:  state_nxt = ST_DUMMY;
                ST_DUMMY: state_nxt = ST_IGNORE;
                ST_DIN:   state_nxt = ST_IGNORE;
                default:  state_nxt = eff_state;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Link domain: frame sequencing
    // ------------------------------------------------------------
    always_ff @(posedge link_sclk or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            state_r      <= ST_IDLE;
            cnt_r        <= 4'h0;
            sh_r         <= 8'h00;
            cmd_r        <= 8'h00;
            addr_r       <= ADDR_RESET;
            rd_val_r     <= 8'h00;
            ones_cnt_r   <= 4'h0;
            ones_run_r   <= 1'b1;
            cont_frame_r <= 1'b0;
        end
        else
        begin
            state_r      <= state_nxt;
            cnt_r        <= (last || state_nxt != eff_state) ? 4'h0 : cnt_r + 4'h1;
            sh_r         <= sh_nxt;
            cont_frame_r <= cont_frame;
            if (eff_state == ST_ADDR)
                addr_r <= addr_nxt;
            if (cmd_done)
            begin
                cmd_r <= sh_nxt;
                case (sh_nxt)
                    OP_READ_SR1: rd_val_r <= sr1_view;
                    OP_READ_SR2: rd_val_r <= sr2_r;
                    OP_READ_EXT: rd_val_r <= ext_addr_r;
                    default:     rd_val_r <= 8'h00;
                endcase
            end
            ones_run_r <= ones_run_r && (link_io_in == ALL_ONES_NIB);
            if (ones_cnt_r != LEN_ONES_4B)
                ones_cnt_r <= ones_cnt_r + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Link domain: addressing and mode state
    // ------------------------------------------------------------
    always_ff @(posedge link_sclk or posedge reset)
    begin
        if (reset)
        begin
            four_byte_r  <= 1'b0;
            cont_read_r  <= 1'b0;
            four_wire_r  <= 1'b0;
            ext_addr_r   <= EXT_ADDR_RESET;
            rd_addr_r    <= ADDR_RESET;
            rd_seq_r     <= 1'b0;
            sreset_seq_r <= 1'b0;
            rst_en_r     <= 1'b0;
        end
        else
        begin
            if (cmd_done)
            begin
                rst_en_r <= (sh_nxt == OP_RESET_EN);
                case (sh_nxt)
                    OP_ENTER_4B:    four_byte_r <= 1'b1;
                    OP_EXIT_4B:     four_byte_r <= 1'b0;
                    OP_ENTER_4WIRE: four_wire_r <= qe;
                    OP_EXIT_4WIRE:  four_wire_r <= 1'b0;
                    OP_RESET:
                    begin
                        if (rst_en_r)
                        begin
                            four_byte_r  <= 1'b0;
                            cont_read_r  <= 1'b0;
                            four_wire_r  <= 1'b0;
                            ext_addr_r   <= EXT_ADDR_RESET;
                            sreset_seq_r <= ~sreset_seq_r;
                        end
                    end
                    default:        four_byte_r <= four_byte_r;
                endcase
            end
            // Volatile segment select; 00h selects the lowest segment
            if (din_done && cmd_r == OP_WRITE_EXT)
                ext_addr_r <= sh_nxt;
            if (ones_exit)
                cont_read_r <= 1'b0;
            else if (mode_done)
            begin
                // Any mode byte other than A5h, 00h included, leaves the mode;
                // the read in progress still runs to its end.
                cont_read_r <= (sh_nxt == MODE_CONT_ENTER) && qe;
                rd_addr_r   <= four_byte_r ? addr_r : {ext_addr_r, addr_r[23:0]};
                rd_seq_r    <= ~rd_seq_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Link domain: status registers and write enables
    // ------------------------------------------------------------
    always_ff @(posedge link_sclk or posedge reset)
    begin
        if (reset)
        begin
            wel_r     <= 1'b0;
            vol_we_r  <= 1'b0;
            vol_act_r <= 1'b0;
            sr1_nv_r  <= SR_RESET;
            sr1_vol_r <= SR_RESET;
            sr2_r     <= SR_RESET;
        end
        else
        begin
            if (cmd_done)
            begin
                case (sh_nxt)
                    OP_WRITE_EN:  wel_r    <= 1'b1;
                    OP_WRITE_DIS: wel_r    <= 1'b0;
                    OP_VOL_SR_WE: vol_we_r <= 1'b1;
                    OP_RESET:
                    begin
                        // Non-volatile copies survive a soft reset
                        if (rst_en_r)
                        begin
                            wel_r     <= 1'b0;
                            vol_we_r  <= 1'b0;
                            vol_act_r <= 1'b0;
                        end
                    end
                    default:      wel_r    <= wel_r;
                endcase
            end
            else if (din_done && (cmd_r == OP_WRITE_SR1 || cmd_r == OP_WRITE_SR2))
            begin
                if (vol_we_r)
                begin
                    if (cmd_r == OP_WRITE_SR1)
                    begin
                        sr1_vol_r <= sh_nxt & SR1_WR_MASK;
                        vol_act_r <= 1'b1;
                    end
                    else
                        sr2_r <= sh_nxt & SR2_WR_MASK;
                    vol_we_r <= 1'b0;
                end
                else if (wel_r)
                begin
                    if (cmd_r == OP_WRITE_SR1)
                        sr1_nv_r <= sh_nxt & SR1_WR_MASK;
                    else
                        sr2_r <= sh_nxt & SR2_WR_MASK;
                    wel_r <= 1'b0;
                end
                // Without either enable the write is dropped
            end
        end
    end

    // ------------------------------------------------------------
    // Link domain: read-out on the falling edge
    // ------------------------------------------------------------
    assign obyte = (ocnt_r == 3'h0) ? rd_val_r : osh_r;

    always_ff @(negedge link_sclk or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            osh_r       <= 8'h00;
            ocnt_r      <= 3'h0;
            link_io_out <= 4'h0;
            link_io_oe  <= 4'h0;
        end
        else if (state_r == ST_DOUT)
        begin
            // Register value repeats for as long as the host clocks
            if (four_wire_r)
            begin
                link_io_out <= obyte[7:4];
                link_io_oe  <= OE_QUAD;
                osh_r       <= {obyte[3:0], 4'h0};
                ocnt_r      <= (ocnt_r == 3'h1) ? 3'h0 : ocnt_r + 3'h1;
            end
            else
            begin
                link_io_out <= {2'b00, obyte[7], 1'b0};
                link_io_oe  <= OE_SINGLE;
                osh_r       <= {obyte[6:0], 1'b0};
                ocnt_r      <= ocnt_r + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Link domain: publish state with a change toggle
    // ------------------------------------------------------------
    always_comb
    begin
        pub_nxt.four_byte_mode         = four_byte_r;
        pub_nxt.cont_read_active       = cont_read_r;
        pub_nxt.four_wire_command_mode = four_wire_r;
        pub_nxt.quad_enable_bit        = qe;
        pub_nxt.volatile_sr1_active    = vol_act_r;
        pub_nxt.status1                = sr1_view;
        pub_nxt.status2                = sr2_r;
        pub_nxt.ext_addr               = ext_addr_r;
        pub_nxt.read_addr              = rd_addr_r;
        pub_nxt.read_seq               = rd_seq_r;
        pub_nxt.sreset_seq             = sreset_seq_r;
    end

    // Falling edge: the host parks the clock low after the last bit, so a
    // change made on the final rising edge still leaves before the clock stops.
    // Changes are a link clock apart, well over the core's capture time.
    always_ff @(negedge link_sclk or posedge reset)
    begin
        if (reset)
        begin
            pub_r     <= '0;
            pub_tog_r <= 1'b0;
        end
        else if (pub_nxt != pub_r)
        begin
            pub_r     <= pub_nxt;
            pub_tog_r <= ~pub_tog_r;
        end
    end

    // ------------------------------------------------------------
    // Core domain: toggle synchroniser and capture
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            tog_sync_r <= 3'b000;
        else
            tog_sync_r <= {tog_sync_r[1:0], pub_tog_r};
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            core_state_r <= '0;
            read_start_r <= 1'b0;
            soft_reset_r <= 1'b0;
        end
        else
        begin
            read_start_r <= 1'b0;
            soft_reset_r <= 1'b0;
            if (tog_sync_r[2] != tog_sync_r[1])
            begin
                core_state_r <= pub_r;
                read_start_r <= pub_r.read_seq != core_state_r.read_seq;
                soft_reset_r <= pub_r.sreset_seq != core_state_r.sreset_seq;
            end
        end
    end

    assign dev_state       = core_state_r;
    assign read_start      = read_start_r;
    assign soft_reset_done = soft_reset_r;

endmodule

`default_nettype wire

/* test/flash_mode_and_addressing_control_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// Bench
// ----
module flash_mode_and_addressing_control_tb_top;
    import fmac_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic sclk, cs_n, rs, srd;
    logic [3:0] hio, io_out, io_oe, io_w;
    fmac_state_t st;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    int reads = 0;
    int sresets = 0;
    logic [7:0] e, d;
    logic [31:0] a;
    always #2 core_clk = ~core_clk;
    assign io_w = (io_oe & io_out) | (~io_oe & hio);
    fmac_top i_fmac_top (.core_clk(core_clk), .reset(reset), .link_sclk(sclk),
        .link_cs_n(cs_n), .link_io_in(io_w), .link_io_out(io_out), .link_io_oe(io_oe),
        .dev_state(st), .read_start(rs), .soft_reset_done(srd));
    fmac_host i_fmac_host (.sclk(sclk), .cs_n(cs_n), .io(hio), .wire_io(io_w));
    // Effective read address: full word in 4-byte mode, else segment on top
    function automatic logic [31:0] seg_addr(input logic w, input logic [7:0] x,
                                             input logic [31:0] ad);
        return w ? ad : {x, ad[23:0]};
    endfunction
    // Pulses are counted mid-cycle, away from the edge that launches them
    always @(negedge core_clk)
    begin
        if (rs === 1'b1)
            reads++;
        if (srd === 1'b1)
            sresets++;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x)
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        if (g !== x)
            miscompares++;
    endtask
    task automatic cmd(input logic [7:0] op);
        i_fmac_host.start();
        i_fmac_host.byte1(op);
        i_fmac_host.stop();
    endtask
    task automatic cmd2(input logic [7:0] op, input logic [7:0] b);
        i_fmac_host.start();
        i_fmac_host.byte1(op);
        i_fmac_host.byte1(b);
        i_fmac_host.stop();
    endtask
    task automatic qrd(input logic c, input logic w, input logic [31:0] ad, input logic [7:0] m);
        i_fmac_host.start();
        if (!c)
            i_fmac_host.byte1(OP_QUAD_IO_READ);
        for (int i = (w ? 28 : 20); i >= 0; i -= 4)
            i_fmac_host.clk4(ad[i+:4]);
        i_fmac_host.nib(m);
        repeat (4) i_fmac_host.clk4(4'h0);
        i_fmac_host.stop();
    endtask
    task automatic end_of_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            miscompares++;
            end_of_test();
        end
    end
    initial
    begin
        void'($urandom(22));
        repeat (20) @(posedge core_clk);
        @(negedge core_clk) reset = 1'b0;
        chk({st.four_byte_mode, st.cont_read_active, st.ext_addr}, 0);
        d = 8'($urandom());
        cmd2(OP_WRITE_SR1, d);
        chk(st.status1, SR_RESET);
        cmd(OP_WRITE_EN);
        cmd2(OP_WRITE_SR1, d);
        chk(st.status1, d & SR1_WR_MASK);
        qrd(1'b0, 1'b0, $urandom(), MODE_CONT_ENTER);
        chk(st.cont_read_active, 1'b0);
        cmd(OP_WRITE_EN);
        cmd2(OP_WRITE_SR2, 8'h02);
        chk(st.quad_enable_bit, 1'b1);
        e = 8'($urandom());
        cmd2(OP_WRITE_EXT, e);
        i_fmac_host.start();
        i_fmac_host.byte1(OP_READ_EXT);
        i_fmac_host.rd();
        i_fmac_host.stop();
        chk(i_fmac_host.rx, e);
        for (int k = 0; k < 2; k++)
        begin
            if (k == 1)
                cmd(OP_ENTER_4B);
            chk(st.four_byte_mode, k[0]);
            a = $urandom();
            qrd(1'b0, k[0], a, MODE_CONT_ENTER);
            chk(st.cont_read_active, 1'b1);
            chk(st.read_addr, seg_addr(k[0], e, a));
            a = $urandom();
            qrd(1'b1, k[0], a, MODE_CONT_EXIT);
            chk({st.cont_read_active, st.read_addr}, {1'b0, seg_addr(k[0], e, a)});
            qrd(1'b0, k[0], a, MODE_CONT_ENTER);
            i_fmac_host.start();
            i_fmac_host.ones(k ? 10 : 8);
            i_fmac_host.stop();
            chk({st.cont_read_active, st.read_addr}, {1'b0, seg_addr(k[0], e, a)});
        end
        cmd(OP_EXIT_4B);
        chk(st.four_byte_mode, 1'b0);
        cmd2(OP_WRITE_EXT, 8'h00);
        chk(st.ext_addr, EXT_ADDR_RESET);
        d = 8'($urandom());
        cmd(OP_VOL_SR_WE);
        cmd2(OP_WRITE_SR1, d);
        chk({st.volatile_sr1_active, st.status1}, {1'b1, d & SR1_WR_MASK});
        cmd(OP_ENTER_4B);
        cmd2(OP_WRITE_EXT, e);
        cmd(OP_RESET);
        chk(st.four_byte_mode, 1'b1);
        cmd(OP_RESET_EN);
        cmd(OP_RESET);
        chk({st.four_byte_mode, st.ext_addr, st.volatile_sr1_active}, 0);
        chk(reads, 32'd6);
        chk(sresets, 32'd1);
        end_of_test();
    end
endmodule
`default_nettype wire

/* test/fmac_chk.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// Port checker
// ----
module fmac_chk
(
    // Core side
    input wire logic                  core_clk,
    input wire logic                  reset,
    // Link pins
    input wire logic                  link_sclk,
    input wire logic                  link_cs_n,
    input wire logic [3:0]            link_io_in,
    input wire logic [3:0]            link_io_out,
    input wire logic [3:0]            link_io_oe,
    // Device state
    input wire fmac_pkg::fmac_state_t dev_state,
    input wire logic                  read_start,
    input wire logic                  soft_reset_done
);
    import fmac_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_idle; link_cs_n |-> link_io_oe == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("drive outside frame");
    property p_quad; link_io_oe == OE_QUAD |-> dev_state.quad_enable_bit; endproperty
    a_quad: assert property (p_quad) else $error("quad drive without enable");
    property p_cont; dev_state.cont_read_active |-> dev_state.quad_enable_bit; endproperty
    a_cont: assert property (p_cont) else $error("continuous read without enable");
    property p_pulse; read_start |=> !read_start; endproperty
    a_pulse: assert property (p_pulse) else $error("read start too long");
    property p_seg;
        read_start && !dev_state.four_byte_mode |->
            ##[0:6] dev_state.read_addr[31:24] == dev_state.ext_addr;
    endproperty
    a_seg: assert property (p_seg) else $error("segment not applied");
    property p_srst;
        soft_reset_done |-> ##[0:8] !dev_state.four_byte_mode && !dev_state.cont_read_active
            && dev_state.ext_addr == EXT_ADDR_RESET && !dev_state.volatile_sr1_active;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset incomplete");
    property p_init;
        $fell(reset) |-> !dev_state.four_byte_mode && !dev_state.cont_read_active
            && dev_state.ext_addr == EXT_ADDR_RESET;
    endproperty
    a_init: assert property (p_init) else $error("bad state after reset");
    property p_wel;
        $changed(dev_state.status1[7:2]) && !dev_state.volatile_sr1_active
            && !$past(dev_state.volatile_sr1_active) |-> $past(dev_state.status1[1]);
    endproperty
    a_wel: assert property (p_wel) else $error("status write without enable");
endmodule
bind fmac_top fmac_chk i_fmac_chk (.core_clk(core_clk), .reset(reset),
    .link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_io_in(link_io_in),
    .link_io_out(link_io_out), .link_io_oe(link_io_oe), .dev_state(dev_state),
    .read_start(read_start), .soft_reset_done(soft_reset_done));
`default_nettype wire

/* test/fmac_host.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// Host controller model
// ----
module fmac_host
(
    // Link pins
    output logic            sclk,
    output logic            cs_n,
    output logic [3:0]      io,
    input  wire logic [3:0] wire_io
);
    logic [7:0] rx;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        io   = 4'h0;
    end
    task automatic clk4(input logic [3:0] v);
        io = v;
        #24 sclk = 1'b1;
        rx = {rx[6:0], wire_io[1]};
        #24 sclk = 1'b0;
    endtask
    task automatic byte1(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            clk4({{3{~b[i]}}, b[i]});
    endtask
    task automatic nib(input logic [7:0] b);
        clk4(b[7:4]);
        clk4(b[3:0]);
    endtask
    // Released lines toggle so a stale level never reads as data
    task automatic rd();
        repeat (8) clk4(~io);
    endtask
    task automatic ones(input int n);
        repeat (n) clk4(4'hf);
    endtask
    // Odd 1 ns keeps the link clock off the core clock phase
    task automatic start();
        #1 cs_n = 1'b0;
        #24;
    endtask
    task automatic stop();
        #24 cs_n = 1'b1;
        #47;
    endtask
endmodule
`default_nettype wire
